//--- logic/psdc_pkg.sv
// constants shared by the synthesizer divider control logic
// assumes one system clock domain plus the serial link clock domain
package psdc_pkg;

  // ==========================================================
  // serial word layout
  localparam int SHIFT_W     = 19;
  localparam int DIV_LATCH_W = 18;
  localparam int REF_LATCH_W = 15;
  localparam int CTRL_POS    = 0;
  localparam int SWAL_W      = 7;
  localparam int MAIN_W      = 11;
  localparam int REF_W       = 14;
  localparam int SWAL_LSB    = 0;
  localparam int MAIN_LSB    = 7;
  localparam int REF_LSB     = 0;
  localparam int RATIO_SEL_POS = 14;

  // ==========================================================
  // values after reset
  localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
  localparam logic [MAIN_W-1:0] MAIN_RST = 11'h010;
  localparam logic [REF_W-1:0]  REF_RST  = 14'h0008;

  // ==========================================================
  // prescaler
  localparam int PRE_W = 8;
  localparam logic [PRE_W-1:0] PRE_LOW_LAST  = 8'h7F;
  localparam logic [PRE_W-1:0] PRE_HIGH_LAST = 8'h80;

  // ==========================================================
  // pin synchroniser slots
  localparam int SY_W   = 5;
  localparam int SY_POL = 0;
  localparam int SY_PS  = 1;
  localparam int SY_LE  = 2;
  localparam int SY_OSC = 3;
  localparam int SY_FIN = 4;

endpackage : psdc_pkg

//--- logic/psdc_shift.sv
// serial shift register on the link clock
// assumes the host keeps data stable around each serial clock rise
`timescale 1ns/1ps
`default_nettype none
module psdc_shift #(
  parameter int W = psdc_pkg::SHIFT_W
) (
  input  wire logic         ser_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ser_data_i,
  output logic [W-1:0]      shift_o
);

  typedef struct packed {
    logic [W-1:0] sr;
  } psdc_shift_s;

  psdc_shift_s st_r;
  psdc_shift_s st_nxt;

  // ==========================================================
  // shifting
  always_comb begin
    st_nxt    = st_r;
    st_nxt.sr = {st_r.sr[W-2:0], ser_data_i};
  end

  always_ff @(posedge ser_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign shift_o = st_r.sr;

endmodule : psdc_shift
`default_nettype wire

//--- logic/psdc_top.sv
// divider, phase comparator and power-save control of the synthesizer
// assumes slow pin inputs (osc, fin) well below half the system clock
`timescale 1ns/1ps
`default_nettype none
module psdc_top (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ser_clk_i,
  input  wire logic ser_data_i,
  input  wire logic load_strobe_i,
  input  wire logic power_save_input_i,
  input  wire logic phase_polarity_select_i,
  input  wire logic osc_i,
  input  wire logic fin_i,
  output logic      cp_o,
  output logic      cp_oe_o,
  output logic      lock_detect_o,
  output logic      bypass_switch_out_o,
  output logic      bypass_switch_oe_o,
  output logic      fr_mon_o,
  output logic      fp_mon_o
);

  localparam int SY_W = psdc_pkg::SY_W;
  localparam int DW   = psdc_pkg::DIV_LATCH_W;
  localparam int RW   = psdc_pkg::REF_LATCH_W;

  typedef struct packed {
    logic [SY_W-1:0]                 sy1;
    logic [SY_W-1:0]                 sy2;
    logic [SY_W-1:0]                 prv;
    logic [RW-1:0]                   ref_latch;
    logic [DW-1:0]                   div_latch;
    logic [psdc_pkg::PRE_W-1:0]      pre_cnt;
    logic [psdc_pkg::SWAL_W-1:0]     swal_cnt;
    logic [psdc_pkg::MAIN_W-1:0]     main_cnt;
    logic [psdc_pkg::REF_W-1:0]      ref_cnt;
    logic                            up;
    logic                            dn;
    logic                            fr_pulse;
    logic                            fp_pulse;
    logic                            cp;
    logic                            cp_oe;
    logic                            lock;
    logic                            byp_oe;
  } psdc_state_s;

  psdc_state_s st_r;
  psdc_state_s st_nxt;

  logic [psdc_pkg::SHIFT_W-1:0] shift_w;

  // ==========================================================
  // link side
  psdc_shift #(
    .W (psdc_pkg::SHIFT_W)
  ) u_shift (
    .ser_clk_i  (ser_clk_i),
    .rst_n_i    (rst_n_i),
    .ser_data_i (ser_data_i),
    .shift_o    (shift_w)
  );

  // ==========================================================
  // helpers
  function automatic logic rise(input logic cur, input logic old);
    rise = cur & ~old;
  endfunction : rise

  function automatic logic [psdc_pkg::SWAL_W-1:0] latch_swal(
    input logic [DW-1:0] l
  );
    latch_swal = l[psdc_pkg::SWAL_LSB +: psdc_pkg::SWAL_W];
  endfunction : latch_swal

  function automatic logic [psdc_pkg::MAIN_W-1:0] latch_main(
    input logic [DW-1:0] l
  );
    latch_main = l[psdc_pkg::MAIN_LSB +: psdc_pkg::MAIN_W];
  endfunction : latch_main

  // ==========================================================
  // next state
  always_comb begin
    logic       le;
    logic       run;
    logic       pol;
    logic       osc_ev;
    logic       fin_ev;
    logic       pre_end;
    logic       fr_ev;
    logic       fp_ev;
    logic       up_n;
    logic       dn_n;
    le      = 1'b0;
    run     = 1'b0;
    pol     = 1'b0;
    osc_ev  = 1'b0;
    fin_ev  = 1'b0;
    pre_end = 1'b0;
    fr_ev   = 1'b0;
    fp_ev   = 1'b0;
    up_n    = 1'b0;
    dn_n    = 1'b0;
    st_nxt  = st_r;

    // first stage feeds only the second stage
    st_nxt.sy1 = {fin_i, osc_i, load_strobe_i, power_save_input_i,
                  phase_polarity_select_i};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.prv = st_r.sy2;

    le     = st_r.sy2[psdc_pkg::SY_LE];
    run    = st_r.sy2[psdc_pkg::SY_PS];
    pol    = st_r.sy2[psdc_pkg::SY_POL];
    osc_ev = rise(st_r.sy2[psdc_pkg::SY_OSC], st_r.prv[psdc_pkg::SY_OSC]);
    fin_ev = rise(st_r.sy2[psdc_pkg::SY_FIN], st_r.prv[psdc_pkg::SY_FIN]);

    // shift word is not gated by the strobe; the host must stop the link clock
    // while it is high, so the multi-bit read across domains sees a settled value
    if (le) begin
      if (shift_w[psdc_pkg::CTRL_POS]) begin
        st_nxt.ref_latch = shift_w[RW:1];
      end else begin
        st_nxt.div_latch = shift_w[DW:1];
      end
    end

    if (!run) begin
      // stand-by: counters parked at their load values so that
      // both dividers start together on release
      st_nxt.pre_cnt  = '0;
      st_nxt.swal_cnt = latch_swal(st_r.div_latch);
      st_nxt.main_cnt = latch_main(st_r.div_latch);
      st_nxt.ref_cnt  = st_r.ref_latch[psdc_pkg::REF_LSB +:
                                       psdc_pkg::REF_W];
      st_nxt.up       = 1'b0;
      st_nxt.dn       = 1'b0;
      st_nxt.fr_pulse = 1'b0;
      st_nxt.fp_pulse = 1'b0;
      st_nxt.cp       = 1'b0;
      st_nxt.cp_oe    = 1'b0;
      st_nxt.lock     = 1'b1;
    end else begin
      // reference divider
      if (osc_ev) begin
        if (st_r.ref_cnt <= 14'h0001) begin
          fr_ev          = 1'b1;
          st_nxt.ref_cnt = st_r.ref_latch[psdc_pkg::REF_LSB +:
                                          psdc_pkg::REF_W];
        end else begin
          st_nxt.ref_cnt = st_r.ref_cnt - 14'h0001;
        end
      end

      // dual-modulus prescaler and pulse swallow counters
      if (fin_ev) begin
        if (st_r.swal_cnt != '0) begin
          pre_end = (st_r.pre_cnt == psdc_pkg::PRE_HIGH_LAST);
        end else begin
          pre_end = (st_r.pre_cnt == psdc_pkg::PRE_LOW_LAST);
        end
        if (pre_end) begin
          st_nxt.pre_cnt = '0;
        end else begin
          st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
        end
      end

      if (pre_end) begin
        if (st_r.swal_cnt != '0) begin
          st_nxt.swal_cnt = st_r.swal_cnt - 7'h01;
        end
        if (st_r.main_cnt <= 11'h001) begin
          fp_ev           = 1'b1;
          st_nxt.main_cnt = latch_main(st_r.div_latch);
          st_nxt.swal_cnt = latch_swal(st_r.div_latch);
        end else begin
          st_nxt.main_cnt = st_r.main_cnt - 11'h001;
        end
      end

      // phase-frequency detector
      up_n = st_r.up | fr_ev;
      dn_n = st_r.dn | fp_ev;
      if (up_n && dn_n) begin
        up_n = 1'b0;
        dn_n = 1'b0;
      end
      st_nxt.up       = up_n;
      st_nxt.dn       = dn_n;
      st_nxt.fr_pulse = fr_ev;
      st_nxt.fp_pulse = fp_ev;

      // charge pump: drive only while one side leads
      st_nxt.cp    = (up_n == pol);
      st_nxt.cp_oe = up_n ^ dn_n;
      st_nxt.lock  = ~(up_n | dn_n);
    end

    st_nxt.byp_oe = le & st_nxt.cp_oe;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r           <= '0;
      st_r.ref_latch <= {1'b0, psdc_pkg::REF_RST};
      st_r.div_latch <= {psdc_pkg::MAIN_RST, psdc_pkg::SWAL_RST};
      st_r.main_cnt  <= psdc_pkg::MAIN_RST;
      st_r.ref_cnt   <= psdc_pkg::REF_RST;
      st_r.lock      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign cp_o                = st_r.cp;
  assign cp_oe_o             = st_r.cp_oe;
  assign lock_detect_o       = st_r.lock;
  assign bypass_switch_out_o = st_r.cp;
  assign bypass_switch_oe_o  = st_r.byp_oe;
  assign fr_mon_o            = st_r.fr_pulse;
  assign fp_mon_o            = st_r.fp_pulse;

endmodule : psdc_top
`default_nettype wire

//--- verif/psdc_assertions.sv
// pin-level checks of the synthesizer divider control
// assumes it is bound to psdc_top; everything sampled on clock_i
`timescale 1ns/1ps
`default_nettype none
module psdc_assertions (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic power_save_input_i,
  input wire logic phase_polarity_select_i,
  input wire logic osc_i,
  input wire logic fin_i,
  input wire logic cp_o,
  input wire logic cp_oe_o,
  input wire logic lock_detect_o,
  input wire logic bypass_switch_out_o,
  input wire logic bypass_switch_oe_o,
  input wire logic fr_mon_o,
  input wire logic fp_mon_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // switch and pump
  bypass_idle_a: assert property (
    !load_strobe_i[*6] |-> !bypass_switch_oe_o) else $error("bypass on");
  bypass_follow_a: assert property (
    bypass_switch_oe_o |-> cp_oe_o && bypass_switch_out_o == cp_o)
    else $error("bypass differs from pump");
  // strobe reaches the switch after two sync stages and one register
  bypass_on_a: assert property (
    $past(load_strobe_i, 3) && cp_oe_o |-> bypass_switch_oe_o)
    else $error("bypass open during strobe");
  lock_pump_a: assert property (
    cp_oe_o |-> !lock_detect_o) else $error("locked while pumping");
  // ==========================================================
  // stand-by and resume; sync latency is three cycles
  standby_float_a: assert property (
    !power_save_input_i[*6] |-> !cp_oe_o && lock_detect_o)
    else $error("stand-by levels wrong");
  standby_quiet_a: assert property (
    !power_save_input_i[*6] |-> !fr_mon_o && !fp_mon_o)
    else $error("counting in stand-by");
  resume_quiet_a: assert property (
    $rose(power_save_input_i) |=> !fr_mon_o[*4])
    else $error("early reference pulse");
  fr_pulse_a: assert property (
    fr_mon_o |=> !fr_mon_o) else $error("reference pulse too long");
  fp_pulse_a: assert property (
    fp_mon_o |=> !fp_mon_o) else $error("divider pulse too long");
  cover property (bypass_switch_oe_o);
  cover property (cp_oe_o && !cp_o);
  cover property (fp_mon_o);
endmodule : psdc_assertions
bind psdc_top psdc_assertions chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .ser_clk_i(ser_clk_i), .ser_data_i(ser_data_i), .osc_i(osc_i),
  .load_strobe_i(load_strobe_i), .power_save_input_i(power_save_input_i),
  .phase_polarity_select_i(phase_polarity_select_i), .fin_i(fin_i),
  .cp_o(cp_o), .cp_oe_o(cp_oe_o), .lock_detect_o(lock_detect_o),
  .bypass_switch_out_o(bypass_switch_out_o), .fr_mon_o(fr_mon_o),
  .bypass_switch_oe_o(bypass_switch_oe_o), .fp_mon_o(fp_mon_o));
`default_nettype wire

//--- verif/psdc_host.sv
// host controller model driving the three-wire programming link
// assumes the caller passes whole words; link clock idles low
`timescale 1ns/1ps
`default_nettype none
module psdc_host (
  input  wire logic clock_i,
  output logic      ser_clk_o,
  output logic      ser_data_o,
  output logic      load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // ==========================================================
  // one word, 6 ns link clock, then an optional strobe
  task automatic send(input logic [18:0] w, input int n, input logic ld);
    int i;
    for (i = n - 1; i >= 0; i--) begin
      ser_data_o = w[i];
      #3 ser_clk_o = 1'b1;
      #3 ser_clk_o = 1'b0;
    end
    ser_data_o = ~ser_data_o;
    @(posedge clock_i);
    load_strobe_o <= ld;
    repeat (8) @(posedge clock_i);
    load_strobe_o <= 1'b0;
    // synced strobe keeps the latch open a few more cycles, so the
    // next word must not start shifting before it has closed
    repeat (4) @(posedge clock_i);
  endtask : send
endmodule : psdc_host
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the synthesizer divider control
// assumes psdc_host drives the link and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       ps      = 1'b0;
  logic       pol     = 1'b1;
  logic       osc     = 1'b0;
  logic       fin     = 1'b0;
  logic [3:0] cnt     = 4'h0;
  logic       sclk, sdat, strobe, cp, cp_oe, lock, bsw, bsw_oe, fr, fp;
  int         mismatches = 0;
  int         n_checks   = 0;
  int         n;
  always #2.5 clock_i = ~clock_i;
  // fin period 4 cycles, osc period 6 cycles
  always @(posedge clock_i) begin
    cnt <= (cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
    fin <= cnt[1];
    osc <= (cnt % 4'h6) < 4'h3;
  end
  psdc_host host (.clock_i(clock_i), .ser_clk_o(sclk), .ser_data_o(sdat),
    .load_strobe_o(strobe));
  psdc_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ser_clk_i(sclk),
    .ser_data_i(sdat), .load_strobe_i(strobe), .power_save_input_i(ps),
    .phase_polarity_select_i(pol), .osc_i(osc), .fin_i(fin), .cp_o(cp),
    .cp_oe_o(cp_oe), .lock_detect_o(lock), .bypass_switch_out_o(bsw),
    .bypass_switch_oe_o(bsw_oe), .fr_mon_o(fr), .fp_mon_o(fp));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_fr(output int k);
    for (k = 0; k < 200; k++) begin
      @(posedge clock_i);
      #1;
      if (fr === 1'b1) return;
    end
    mismatches++;
    report_and_stop();
  endtask : wait_fr
  // cycles between two consecutive monitor pulses
  task automatic gap(input logic use_fp, input logic [31:0] exp_c);
    int k;
    int first;
    first = -1;
    for (k = 0; k < 20000; k++) begin
      @(posedge clock_i);
      #1;
      if ((use_fp ? fp : fr) === 1'b1) begin
        if (first >= 0) begin
          check(32'(k - first), exp_c);
          return;
        end
        first = k;
      end
    end
    mismatches++;
    report_and_stop();
  endtask : gap
  // ==========================================================
  // scenarios
  task automatic scn_standby;
    #1;
    check(cp_oe, 1'b0);
    check(lock, 1'b1);
    host.send({1'b0, 14'h0008, 1'b1, 3'h0} >> 3, 16, 1'b1);
    host.send({11'h010, 7'h01, 1'b0}, 19, 1'b1);
    #1;
    check(bsw_oe, 1'b0);
  endtask : scn_standby
  task automatic scn_divide;
    @(posedge clock_i);
    ps <= 1'b1;
    gap(1'b0, 32'h30);
    gap(1'b1, 32'h2004);
    host.send({11'h020, 7'h05, 1'b0}, 19, 1'b0);
    gap(1'b1, 32'h2004);
    host.send({11'h011, 7'h00, 1'b0}, 19, 1'b1);
    #1;
    check(bsw_oe, 1'b0);
    gap(1'b1, 32'h2200);
  endtask : scn_divide
  // reference runs far faster, so the pump pushes up
  task automatic scn_polarity(input logic p);
    @(posedge clock_i);
    pol <= p;
    wait_fr(n);
    wait_fr(n);
    // looked at on the reference pulse itself, before a divider
    // pulse can clear the pending up flag
    check(cp_oe, 1'b1);
    check(lock, 1'b0);
    check(cp, p);
    check(bsw, p);
  endtask : scn_polarity
  task automatic scn_resume;
    @(posedge clock_i);
    ps <= 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
    check({cp_oe, lock, fr}, 3'h2);
    @(posedge clock_i);
    ps <= 1'b1;
    wait_fr(n);
    check(n >= 40 && n <= 60, 1'b1);
  endtask : scn_resume
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    scn_standby();
    scn_divide();
    scn_polarity(1'b1);
    scn_polarity(1'b0);
    scn_resume();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
